// [logic/sarseq_core.sv]
// Purpose: successive-approximation sequencer with power and mux control
// Assumes: comparator_i is synchronous to clock_i after the analog latch
// Notes: read_busy_i comes from the serial slave on the same clock
`include "sarseq_defines.svh"
`default_nettype none
module sarseq_core #(
    parameter int WIDTH = 8,
    parameter int ACQ_CYC = `SARSEQ_ACQ_CYC,
    parameter int PHASE_CYC = `SARSEQ_PHASE_CYC
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] command_i,
    input wire logic command_load_i,
    input wire logic start_i,
    input wire logic addressed_i,
    input wire logic read_busy_i,
    input wire logic comparator_i,
    output logic [7:0] pos_sel_o,
    output logic [7:0] neg_sel_o,
    output logic common_neg_o,
    output logic sample_top_o,
    output logic sample_bottom_o,
    output logic phase1_o,
    output logic phase2_o,
    output logic [WIDTH-1:0] dac_word_o,
    output logic [WIDTH-1:0] result_o,
    output logic result_valid_o,
    output logic busy_o,
    output logic core_power_o,
    output logic core_clock_en_o,
    output logic reference_on_o
);
    ////////////////////////////////////////////////////////////////////////
    sarseq_pkg::sarseq_state_t state_r, state_nxt;
    logic [7:0] cmd_r;
    logic [WIDTH-1:0] approximation_register_r;
    logic [WIDTH-1:0] trial_bit_r;
    logic [15:0] cnt_r;
    logic pend_r;
    logic single_ended_select;
    logic [2:0] channel_select_bits;
    logic [1:0] power_mode_bits;
    logic phase_end;

    assign single_ended_select = cmd_r[`SARSEQ_CMD_SE_BIT];
    assign channel_select_bits = cmd_r[`SARSEQ_CMD_CH_HI:`SARSEQ_CMD_CH_LO];
    assign power_mode_bits = cmd_r[`SARSEQ_CMD_PD_HI:`SARSEQ_CMD_PD_LO];

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            cmd_r <= 8'h00;
        end else if (command_load_i) begin
            cmd_r <= command_i;
        end
    end

    sarseq_mux_decode u_mux (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .single_ended_select_i(single_ended_select),
        .channel_select_bits_i(channel_select_bits),
        .pos_sel_o(pos_sel_o),
        .neg_sel_o(neg_sel_o),
        .common_neg_o(common_neg_o)
    );

    ////////////////////////////////////////////////////////////////////////
    assign phase_end = (cnt_r == 16'(PHASE_CYC - 1));

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            sarseq_pkg::SARSEQ_IDLE: begin
                if (start_i || pend_r) begin
                    state_nxt = sarseq_pkg::SARSEQ_ACQ;
                end
            end
            sarseq_pkg::SARSEQ_ACQ: begin
                if (cnt_r == 16'(ACQ_CYC - 1)) begin
                    state_nxt = sarseq_pkg::SARSEQ_HOLD;
                end
            end
            sarseq_pkg::SARSEQ_HOLD: begin
                state_nxt = sarseq_pkg::SARSEQ_PH1;
            end
            sarseq_pkg::SARSEQ_PH1: begin
                if (phase_end) begin
                    state_nxt = sarseq_pkg::SARSEQ_PH2;
                end
            end
            sarseq_pkg::SARSEQ_PH2: begin
                if (phase_end) begin
                    // last trial at lsb ends the run
                    state_nxt = trial_bit_r[0] ? sarseq_pkg::SARSEQ_DONE
                                               : sarseq_pkg::SARSEQ_PH1;
                end
            end
            sarseq_pkg::SARSEQ_DONE: begin
                // publishing waits for the read to finish
                if (!read_busy_i) begin
                    state_nxt = sarseq_pkg::SARSEQ_IDLE;
                end
            end
            default: state_nxt = sarseq_pkg::SARSEQ_IDLE;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            state_r <= sarseq_pkg::SARSEQ_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            cnt_r <= 16'h0000;
        end else if (state_nxt != state_r) begin
            cnt_r <= 16'h0000;
        end else if (state_r == sarseq_pkg::SARSEQ_ACQ || state_r == sarseq_pkg::SARSEQ_PH1 ||
                     state_r == sarseq_pkg::SARSEQ_PH2) begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end

    // a start seen while busy is kept so it is not lost
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            pend_r <= 1'b0;
        end else if (start_i && state_r != sarseq_pkg::SARSEQ_IDLE) begin
            pend_r <= 1'b1;
        end else if (state_r == sarseq_pkg::SARSEQ_IDLE) begin
            pend_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            approximation_register_r <= '0;
            trial_bit_r <= '0;
        end else if (state_r == sarseq_pkg::SARSEQ_HOLD) begin
            approximation_register_r <= {1'b1, {(WIDTH-1){1'b0}}};
            trial_bit_r <= {1'b1, {(WIDTH-1){1'b0}}};
        end else if (state_r == sarseq_pkg::SARSEQ_PH2 && phase_end) begin
            if (comparator_i) begin
                approximation_register_r <= approximation_register_r | (trial_bit_r >> 1);
            end else begin
                approximation_register_r <= (approximation_register_r & ~trial_bit_r)
                                            | (trial_bit_r >> 1);
            end
            trial_bit_r <= trial_bit_r >> 1;
        end
    end

    // result only moves when no read is running
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            result_o <= WIDTH'(`SARSEQ_RESULT_RESET);
            result_valid_o <= 1'b0;
        end else if (state_r == sarseq_pkg::SARSEQ_DONE && !read_busy_i) begin
            result_o <= approximation_register_r;
            result_valid_o <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            sample_top_o <= 1'b0;
            sample_bottom_o <= 1'b0;
            phase1_o <= 1'b0;
            phase2_o <= 1'b0;
            dac_word_o <= '0;
        end else begin
            // both switches open outside acquisition
            sample_top_o <= (state_nxt == sarseq_pkg::SARSEQ_ACQ);
            sample_bottom_o <= (state_nxt == sarseq_pkg::SARSEQ_ACQ);
            // one-hot states keep the phases apart by construction
            phase1_o <= (state_nxt == sarseq_pkg::SARSEQ_PH1);
            phase2_o <= (state_nxt == sarseq_pkg::SARSEQ_PH2);
            dac_word_o <= (state_r == sarseq_pkg::SARSEQ_HOLD) ? {1'b1, {(WIDTH-1){1'b0}}}
                        : (state_r == sarseq_pkg::SARSEQ_PH2 && phase_end)
                          ? ((comparator_i ? approximation_register_r
                              : (approximation_register_r & ~trial_bit_r)) | (trial_bit_r >> 1))
                          : approximation_register_r;
        end
    end

    assign busy_o = (state_r != sarseq_pkg::SARSEQ_IDLE);

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            core_power_o <= 1'b0;
            core_clock_en_o <= 1'b0;
            reference_on_o <= 1'b0;
        end else begin
            core_power_o <= (state_nxt != sarseq_pkg::SARSEQ_IDLE) || addressed_i ||
                            power_mode_bits[0];
            core_clock_en_o <= (state_nxt != sarseq_pkg::SARSEQ_IDLE) || addressed_i;
            reference_on_o <= power_mode_bits[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    chk_phase_apart: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        !(phase1_o && phase2_o)) else $error("phases overlap");
    chk_switch_open: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (phase1_o || phase2_o) |-> !sample_top_o && !sample_bottom_o)
        else $error("switches closed in conversion");
    chk_msb_load: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        state_r == sarseq_pkg::SARSEQ_HOLD |=> approximation_register_r == 8'h80)
        else $error("start word wrong");
    chk_first_trial: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        state_r == sarseq_pkg::SARSEQ_HOLD |=> dac_word_o == 8'h80)
        else $error("first dac level not half");
    chk_bit_keep: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        state_r == sarseq_pkg::SARSEQ_PH2 && phase_end && comparator_i |=>
        (approximation_register_r & $past(trial_bit_r)) != 8'h00)
        else $error("bit not kept");
    chk_bit_clear: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        state_r == sarseq_pkg::SARSEQ_PH2 && phase_end && !comparator_i |=>
        (approximation_register_r & $past(trial_bit_r)) == 8'h00)
        else $error("bit not cleared");
    chk_eight_periods: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        state_r == sarseq_pkg::SARSEQ_HOLD |=> ##32 state_r == sarseq_pkg::SARSEQ_DONE)
        else $error("conversion length wrong");
    chk_read_stable: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        read_busy_i |=> $stable(result_o)) else $error("result moved during read");
    chk_acq_first: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        $rose(phase1_o) && $past(state_r) == sarseq_pkg::SARSEQ_HOLD |->
        $past(sample_top_o, 2)) else $error("no acquisition before conversion");
    // judged from the visible state, so a wrong enable term cannot hide
    chk_power_off: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        !$past(sys_rst_i) |-> core_clock_en_o == (busy_o || $past(addressed_i)))
        else $error("core clock not following activity");
endmodule // sarseq_core
`default_nettype wire

// [common/sarseq_defines.svh]
// Purpose: constants for the approximation sequencer
// Assumes: 100 MHz clock_i, synchronous active-high reset
// Notes: command byte layout and phase timing counts
// Operation
// - eight-bit result, one approximation period per bit, eight periods total
// - eight-way input mux, only the selected input is routed to the converter
// - every conversion runs acquisition first, then conversion
// - after acquisition open top-plate and bottom-plate switches to isolate charge
// - conversion uses two non-overlapping phases: ground bottom plates, then apply trial
// - conversion start loads register with only the top bit set
// - trial word drives the dac; first trial equals half reference
// - keep trial bit on comparator high, clear it on comparator low
// - hold decided bits, set next lower bit as trial, repeat to lsb
// - approximation register holds the final result
// - held result is presented for reading over the serial interface
// - command bit 7 selects single-ended, bits 6..4 select channel and polarity
// - command bits 3..2 select power mode
// - core and internal clock are off when not converting and not addressed; core power here also stays on while command bit 2 is set
`ifndef SARSEQ_DEFINES_SVH
`define SARSEQ_DEFINES_SVH
`define SARSEQ_CMD_SE_BIT 7
`define SARSEQ_CMD_CH_HI 6
`define SARSEQ_CMD_CH_LO 4
`define SARSEQ_CMD_PD_HI 3
`define SARSEQ_CMD_PD_LO 2
`define SARSEQ_RESULT_RESET 8'h00
`define SARSEQ_ACQ_NS 200
`define SARSEQ_CLK_NS 10
`define SARSEQ_ACQ_CYC ((`SARSEQ_ACQ_NS + `SARSEQ_CLK_NS - 1) / `SARSEQ_CLK_NS)
`define SARSEQ_PHASE_CYC 2
`endif

// [common/sarseq_pkg.sv]
// Purpose: types for the approximation sequencer
// Assumes: nothing
// Notes: one-hot state and power mode codes
`default_nettype none
package sarseq_pkg;
    typedef enum logic [5:0] {
        SARSEQ_IDLE  = 6'b00_0001,
        SARSEQ_ACQ   = 6'b00_0010,
        SARSEQ_HOLD  = 6'b00_0100,
        SARSEQ_PH1   = 6'b00_1000,
        SARSEQ_PH2   = 6'b01_0000,
        SARSEQ_DONE  = 6'b10_0000
    } sarseq_state_t;
    typedef enum logic [1:0] {
        SARSEQ_PD_BETWEEN = 2'b00,
        SARSEQ_PD_REFOFF  = 2'b01,
        SARSEQ_PD_ADCOFF  = 2'b10,
        SARSEQ_PD_ALLON   = 2'b11
    } sarseq_pwr_t;
endpackage
`default_nettype wire

// [logic/sarseq_mux_decode.sv]
// Purpose: analog mux select decode from the command byte
// Assumes: command fields already registered
// Notes: outputs registered so switch controls never glitch
`include "sarseq_defines.svh"
`default_nettype none
module sarseq_mux_decode (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic single_ended_select_i,
    input wire logic [2:0] channel_select_bits_i,
    output logic [7:0] pos_sel_o,
    output logic [7:0] neg_sel_o,
    output logic common_neg_o
);
    logic [2:0] pair;
    assign pair = {1'b0, channel_select_bits_i[1:0]} << 1;
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            pos_sel_o <= 8'h00;
            neg_sel_o <= 8'h00;
            common_neg_o <= 1'b0;
        end else begin
            // one-hot selects: one input per side, or the positive one against common when single-ended
            pos_sel_o <= 8'h01 << (pair + {2'b00, channel_select_bits_i[2]});
            if (single_ended_select_i) begin
                neg_sel_o <= 8'h00;
                common_neg_o <= 1'b1;
            end else begin
                neg_sel_o <= 8'h01 << (pair + {2'b00, ~channel_select_bits_i[2]});
                common_neg_o <= 1'b0;
            end
        end
    end
endmodule // sarseq_mux_decode
`default_nettype wire

// [tb/sarseq_far_model.sv]
// Purpose: far-side model: comparator against a sampled input level, and a result reader
// Assumes: level held in vin_i stands still for a whole conversion
// Notes: comparator follows the trial word at once, settled well before phase two ends
`default_nettype none
module sarseq_far_model (
    input wire logic [7:0] vin_i,
    input wire logic [7:0] dac_word_i,
    input wire logic read_en_i,
    output logic comparator_o,
    output logic read_busy_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // high keeps the trial bit, so the search settles on vin_i itself
    assign comparator_o = (vin_i >= dac_word_i);
    // a read in progress is a level for the whole transfer
    assign read_busy_o = read_en_i;
endmodule // sarseq_far_model
`default_nettype wire

// [tb/sar_conversion_sequencer_tb_top.sv]
// Purpose: self-checking bench for the approximation sequencer
// Assumes: default counts, twenty acquisition cycles and two cycles a phase
// Notes: random input levels and commands from a fixed seed, corners among them
`default_nettype none
module sar_conversion_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i, sys_rst_i, command_load_i, start_i, addressed_i, read_en, comparator, read_busy;
    logic [7:0] command_i, vin, pos_sel, neg_sel, dac_word, result, prev;
    logic common_neg, s_top, s_bot, ph1, ph2, valid, busy, c_pwr, c_clk, ref_on;
    int err_count, num_checks, seed, ph2_cnt, p;
    sarseq_core u_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .command_i(command_i),
        .command_load_i(command_load_i), .start_i(start_i), .addressed_i(addressed_i),
        .read_busy_i(read_busy), .comparator_i(comparator), .pos_sel_o(pos_sel),
        .neg_sel_o(neg_sel), .common_neg_o(common_neg), .sample_top_o(s_top),
        .sample_bottom_o(s_bot), .phase1_o(ph1), .phase2_o(ph2), .dac_word_o(dac_word),
        .result_o(result), .result_valid_o(valid), .busy_o(busy), .core_power_o(c_pwr),
        .core_clock_en_o(c_clk), .reference_on_o(ref_on));
    sarseq_far_model u_far (.vin_i(vin), .dac_word_i(dac_word), .read_en_i(read_en),
        .comparator_o(comparator), .read_busy_o(read_busy));
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tick();
        @(posedge clock_i);
        #1;
    endtask
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // phases must never overlap and the first trial must be the half-scale word
    always @(posedge clock_i) begin
        if (!sys_rst_i && ph1 === 1'b1) chk("phase_overlap", 8'h00, {7'h00, ph2});
        if (!sys_rst_i && ph1 === 1'b1) chk("plates_open", 8'h00, {6'h00, s_top, s_bot});
        if (ph2 === 1'b1 && ph2_cnt == 0) chk("first_trial", 8'h80, dac_word);
        if (ph2 === 1'b1) ph2_cnt++;
    end
    task automatic wait_idle();
        int k;
        k = 0;
        while (busy !== 1'b0 && k < 200) begin
            tick();
            k++;
        end
        if (k >= 200) begin
            err_count++;
            $display("FAIL busy_timeout expected 0 seen 1");
            print_verdict();
        end
    endtask
    // hold keeps the reader busy from start for hold plus six cycles
    task automatic convert(input logic [7:0] v, input int hold);
        int k;
        vin = v;
        ph2_cnt = 0;
        prev = result;
        read_en = (hold > 0);
        start_i = 1'b1;
        tick();
        start_i = 1'b0;
        tick();
        chk("acq_plates", 8'h03, {6'h00, s_top, s_bot});
        repeat (4) tick();
        chk("core_on_busy", 8'h01, {7'h00, c_pwr});
        chk("clock_on_busy", 8'h01, {7'h00, c_clk});
        for (k = 0; k < hold; k++) tick();
        if (hold > 0) chk("result_frozen", prev, result);
        read_en = 1'b0;
        wait_idle();
        repeat (2) tick();
        chk("phase2_cycles", 8'h10, 8'(ph2_cnt));
        chk("result", v, result);
        chk("valid", 8'h01, {7'h00, valid});
    endtask
    task automatic load(input logic [7:0] c);
        command_i = c;
        command_load_i = 1'b1;
        tick();
        command_load_i = 1'b0;
        repeat (3) tick();
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 1282;
        err_count = 0;
        num_checks = 0;
        ph2_cnt = 1;
        {sys_rst_i, command_load_i, start_i, addressed_i, read_en} = 5'b1_0000;
        command_i = 8'h00;
        vin = 8'h00;
        repeat (20) tick();
        sys_rst_i = 1'b0;
        tick();
        chk("reset_result", 8'h00, result);
        chk("reset_flags", 8'h00, {6'h00, valid, busy});
        $display("test reset done");
        // every select code, single-ended and differential
        for (int c = 0; c < 16; c++) begin
            load(8'(c << 4));
            p = 2 * (c & 3) + ((c >> 2) & 1);
            chk("pos_sel", 8'(1 << p), pos_sel);
            chk("neg_sel", c[3] ? 8'h00 : 8'(1 << (p ^ 1)), neg_sel);
            chk("common_neg", {7'h00, c[3]}, {7'h00, common_neg});
        end
        $display("test mux select done");
        // idle power state for each mode, not addressed
        for (int m = 0; m < 4; m++) begin
            load(8'(m << 2));
            chk("reference_on", {7'h00, m[1]}, {7'h00, ref_on});
            chk("core_idle", {7'h00, m[0]}, {7'h00, c_pwr});
            if (m == 0) chk("clock_idle", 8'h00, {7'h00, c_clk});
        end
        // being addressed alone must wake the core and its clock
        load(8'h00);
        addressed_i = 1'b1;
        repeat (2) tick();
        chk("clock_addressed", 8'h01, {7'h00, c_clk});
        chk("core_addressed", 8'h01, {7'h00, c_pwr});
        addressed_i = 1'b0;
        repeat (2) tick();
        chk("clock_released", 8'h00, {7'h00, c_clk});
        $display("test power modes done");
        foreach (prev[i]) convert(8'h01 << i, 0);
        convert(8'h00, 0);
        convert(8'hff, 0);
        convert(8'h7f, 0);
        $display("test corner codes done");
        for (int i = 0; i < 12; i++) begin
            load(8'($random(seed)));
            convert(8'($random(seed)), 0);
        end
        $display("test random conversions done");
        convert(8'h5a, 80);
        convert(8'ha5, 70);
        $display("test read stall done");
        // a start seen while busy is kept and runs once the first is over
        vin = 8'h3c;
        start_i = 1'b1;
        repeat (2) tick();
        start_i = 1'b0;
        wait_idle();
        tick();
        chk("queued_start", 8'h01, {7'h00, busy});
        wait_idle();
        repeat (2) tick();
        chk("queued_result", 8'h3c, result);
        $display("test queued start done");
        print_verdict();
    end
endmodule // sar_conversion_sequencer_tb_top
`default_nettype wire
